// ===== hw/addr_high_io_defs.svh
// Constant definitions for the address-high general-purpose port
`ifndef ADDR_HIGH_IO_DEFS_SVH
`define ADDR_HIGH_IO_DEFS_SVH

// Register offsets in the processor address space
`define AHIO_OFS_PULLUP    16'hffad
`define AHIO_OFS_DIRECTION 16'hffb1
`define AHIO_OFS_LATCH     16'hffb3

// Register widths and reset values
`define AHIO_WIDTH         8
`define AHIO_ZERO          8'h00
`define AHIO_ALL_ONES      8'hff

// Read value of the write-only direction register
`define AHIO_DIR_READBACK  8'hff

// Read value of an unmapped address
`define AHIO_UNMAPPED_READ 8'h00

// Operating mode codes on the mode input
`define AHIO_MODE_CODE_1   2'h1
`define AHIO_MODE_CODE_2   2'h2
`define AHIO_MODE_CODE_3   2'h3

`endif

// ===== hw/addr_high_io_pkg.sv
// Types shared by the address-high general-purpose port
package addr_high_io_pkg;

    // Decoded operating mode
    typedef enum logic [1:0] {
        MODE_EXP_NO_ROM,
        MODE_EXP_ROM,
        MODE_SINGLE_CHIP
    } op_mode_t;

endpackage

// ===== hw/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Raw and filtered levels
    input  wire logic [WIDTH-1:0] raw_in,
    output var  logic [WIDTH-1:0] level_out
);

    ////////////////////////////////////////////////////////////////////
    // One lane per pin
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_lane
            logic stage1_r;     // Metastable stage, read by stage2 only
            logic stage2_r;     // Second stage
            logic stage3_r;     // Third stage
            logic level_r;      // Accepted level
            logic level_nxt;    // Next accepted level

            // Take a change only once stages two and three agree
            always_comb begin
                level_nxt = level_r;
                if (stage2_r == stage3_r) begin
                    level_nxt = stage3_r;
                end
            end

            // Shift chain and accepted level
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    stage1_r <= 1'b0;
                    stage2_r <= 1'b0;
                    stage3_r <= 1'b0;
                    level_r  <= 1'b0;
                end else begin
                    stage1_r <= raw_in[g];
                    stage2_r <= stage1_r;
                    stage3_r <= stage2_r;
                    level_r  <= level_nxt;
                end
            end

            assign level_out[g] = level_r;
        end
    endgenerate

endmodule

`default_nettype wire

// ===== hw/port_reg8.sv
// One port control register with clear, force-to-ones and write
`timescale 1ns/1ps
`default_nettype none

module port_reg8 #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Control
    input  wire logic             clear_in,
    input  wire logic             force_in,
    input  wire logic             wr_in,
    input  wire logic [WIDTH-1:0] wdata_in,
    // Stored value
    output var  logic [WIDTH-1:0] value_out
);

    logic [WIDTH-1:0] value_r;      // Stored bits
    logic [WIDTH-1:0] value_nxt;    // Next stored bits

    ////////////////////////////////////////////////////////////////////
    // Clear beats force, force beats a software write
    always_comb begin
        value_nxt = value_r;
        if (clear_in) begin
            value_nxt = '0;
        end else if (force_in) begin
            value_nxt = '1;
        end else if (wr_in) begin
            value_nxt = wdata_in;
        end
    end

    // Reset value is all zeros
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            value_r <= '0;
        end else begin
            value_r <= value_nxt;
        end
    end

    assign value_out = value_r;

endmodule

`default_nettype wire

// ===== hw/addr_high_io_port.sv
// Eight-bit general-purpose port doubling as upper address byte
`timescale 1ns/1ps
`default_nettype none

`include "addr_high_io_defs.svh"

module addr_high_io_port #(
    parameter int WIDTH = `AHIO_WIDTH
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Operating mode and standby, from system logic on this clock
    input  wire logic [1:0]       mode_in,
    input  wire logic             hw_standby_in,
    input  wire logic             sw_standby_in,
    // Upper byte of the current bus-cycle address
    input  wire logic [WIDTH-1:0] bus_addr_hi_in,
    // Register port
    input  wire logic [15:0]      reg_addr_in,
    input  wire logic [WIDTH-1:0] reg_wdata_in,
    input  wire logic             reg_wr_in,
    input  wire logic             reg_rd_in,
    output var  logic [WIDTH-1:0] reg_rdata_out,
    // Port pins
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] pin_out,
    output var  logic [WIDTH-1:0] pin_oe_n_out,
    output var  logic [WIDTH-1:0] pullup_en_out
);

    ////////////////////////////////////////////////////////////////////
    // Reset release synchroniser

    logic rst_meta_r;   // First release stage
    logic rst_sync_r;   // Released reset used by the block

    // Assert at once, release after two edges
    // A bare release could land near an edge and split the
    // registers across two cycles; the two stages prevent that
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Mode decode

    addr_high_io_pkg::op_mode_t mode_sel;   // Decoded mode
    logic                       mode1;      // Expanded, no on-chip ROM
    logic                       mode2;      // Expanded, with on-chip ROM

    // Unknown code falls back to single chip, the safest choice
    always_comb begin
        unique case (mode_in)
            // Expanded bus, every pin carries address
            `AHIO_MODE_CODE_1: begin
                mode_sel = addr_high_io_pkg::MODE_EXP_NO_ROM;
            end
            // Expanded bus, address chosen per pin
            `AHIO_MODE_CODE_2: begin
                mode_sel = addr_high_io_pkg::MODE_EXP_ROM;
            end
            // Single chip, no address function
            `AHIO_MODE_CODE_3: begin
                mode_sel = addr_high_io_pkg::MODE_SINGLE_CHIP;
            end
            // Code zero is not a legal mode
            default: begin
                mode_sel = addr_high_io_pkg::MODE_SINGLE_CHIP;
            end
        endcase
    end

    // Single chip needs no flag of its own: it is neither of these
    assign mode1 = (mode_sel == addr_high_io_pkg::MODE_EXP_NO_ROM);
    assign mode2 = (mode_sel == addr_high_io_pkg::MODE_EXP_ROM);

    ////////////////////////////////////////////////////////////////////
    // Register write decode

    logic             wr_allowed;   // Processor running, write present
    logic             wr_dir;       // Direction register write
    logic             wr_latch;     // Output latch write
    logic             wr_pullup;    // Pull-up control write
    logic             dir_clear;    // Direction cleared in hardware standby
    logic [WIDTH-1:0] dir_q;        // Direction bits
    logic [WIDTH-1:0] latch_q;      // Output latch bits
    logic [WIDTH-1:0] pullup_q;     // Pull-up control bits

    // Writes are dropped in either standby; the processor is halted
    // so a stray strobe during wake-up cannot disturb the port
    assign wr_allowed = reg_wr_in && !hw_standby_in && !sw_standby_in;
    assign wr_latch   = wr_allowed && (reg_addr_in == `AHIO_OFS_LATCH);
    assign wr_pullup  = wr_allowed && (reg_addr_in == `AHIO_OFS_PULLUP);

    assign wr_dir = wr_allowed && !mode1
                 && (reg_addr_in == `AHIO_OFS_DIRECTION);

    // hardware standby clears direction outside mode 1
    assign dir_clear = hw_standby_in && !mode1;

    ////////////////////////////////////////////////////////////////////
    // Register storage

    // Mode 1 forces ones on every edge, so no write can clear them
    // direction forced to ones after reset in mode 1
    port_reg8 #(
        .WIDTH     (WIDTH)
    ) u_dir (
        .clk_in    (clk_in),
        .rst_n_in  (rst_sync_r),
        .clear_in  (dir_clear),
        .force_in  (mode1),
        .wr_in     (wr_dir),
        .wdata_in  (reg_wdata_in),
        .value_out (dir_q)
    );

    port_reg8 #(
        .WIDTH     (WIDTH)
    ) u_latch (
        .clk_in    (clk_in),
        .rst_n_in  (rst_sync_r),
        .clear_in  (hw_standby_in),
        .force_in  (1'b0),
        .wr_in     (wr_latch),
        .wdata_in  (reg_wdata_in),
        .value_out (latch_q)
    );

    // pull-up control cleared in hardware standby
    // Software standby leaves it alone as well
    port_reg8 #(
        .WIDTH     (WIDTH)
    ) u_pullup (
        .clk_in    (clk_in),
        .rst_n_in  (rst_sync_r),
        .clear_in  (hw_standby_in),
        .force_in  (1'b0),
        .wr_in     (wr_pullup),
        .wdata_in  (reg_wdata_in),
        .value_out (pullup_q)
    );

    ////////////////////////////////////////////////////////////////////
    // Pin input synchroniser

    logic [WIDTH-1:0] pin_level;    // Filtered pin levels

    // Pins are asynchronous to the clock
    // Limitation: a pin change reaches reads some four cycles late
    // and a pin that toggles every cycle is never accepted
    // Filter runs on the released reset so it starts from a known level
    pin_sync3 #(
        .WIDTH     (WIDTH)
    ) u_pin_sync (
        .clk_in    (clk_in),
        .rst_n_in  (rst_sync_r),
        .raw_in    (pin_in),
        .level_out (pin_level)
    );

    ////////////////////////////////////////////////////////////////////
    // Per-pin function

    logic [WIDTH-1:0] addr_fn;          // Pin carries an address bit
    logic [WIDTH-1:0] gp_out;           // Pin is a general output
    logic [WIDTH-1:0] pin_nxt;          // Next pin level
    logic [WIDTH-1:0] oe_n_nxt;         // Next enable, low drives
    logic [WIDTH-1:0] pullup_nxt;       // Next pull-up enable
    logic [WIDTH-1:0] read_bits;        // Latch or pin per bit

    // One lane per pin; every lane sees the same mode and standby
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            // mode 1 makes every pin an address pin
            // mode 2 chooses per pin by direction
            assign addr_fn[g] = mode1 || (mode2 && dir_q[g]);

            // direction one makes an output
            // An address pin is never also a general output
            assign gp_out[g] = !addr_fn[g] && dir_q[g];

            // address pins follow the bus address
            // software standby holds address pins low
            // Low, not floating, so the bus holds a defined level
            assign pin_nxt[g] = addr_fn[g]
                              ? (bus_addr_hi_in[g] && !sw_standby_in)
                              : latch_q[g];

            // hardware standby floats every pin
            // Otherwise driven only as address or general output
            assign oe_n_nxt[g] = hw_standby_in
                              || !(addr_fn[g] || gp_out[g]);

            // pull-up needs input direction and control set
            // never a pull-up in mode 1
            // each control bit acts on its own pin only
            // Off in hardware standby even before the control clears
            assign pullup_nxt[g] = pullup_q[g] && !dir_q[g]
                                && !mode1 && !hw_standby_in;

            // outputs read latch, inputs read the pin
            assign read_bits[g] = dir_q[g] ? latch_q[g] : pin_level[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Read data

    logic [WIDTH-1:0] rdata_r;      // Read data, valid one cycle
    logic [WIDTH-1:0] rdata_nxt;    // Next read data

    // Read data stands only in the cycle after the strobe
    // An output bit reads the latch even while its pin carries an
    // address bit, so software sees what it wrote
    always_comb begin
        rdata_nxt = `AHIO_ZERO;
        // No strobe: zero, so stale data never lingers
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                `AHIO_OFS_LATCH: begin
                    rdata_nxt = read_bits;
                end
                `AHIO_OFS_PULLUP: begin
                    rdata_nxt = pullup_q;
                end
                `AHIO_OFS_DIRECTION: begin
                    rdata_nxt = `AHIO_DIR_READBACK;
                end
                // Unmapped addresses read a fixed value
                default: begin
                    rdata_nxt = `AHIO_UNMAPPED_READ;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output registers

    logic [WIDTH-1:0] pin_r;        // Driven pin level
    logic [WIDTH-1:0] oe_n_r;       // Output enable, low drives
    logic [WIDTH-1:0] pullup_r;     // Pull-up enables

    // Registering every pin control keeps glitches off the pads,
    // at the cost of one cycle of lag behind the bus address
    // Pin level is unused while floating; zero keeps it defined
    // reset leaves pins floating, pull-ups off
    always_ff @(posedge clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            pin_r    <= `AHIO_ZERO;
            oe_n_r   <= `AHIO_ALL_ONES;
            pullup_r <= `AHIO_ZERO;
            rdata_r  <= `AHIO_ZERO;
        end else begin
            pin_r    <= pin_nxt;
            oe_n_r   <= oe_n_nxt;
            pullup_r <= pullup_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    // Every output comes straight from a flop
    assign pin_out       = pin_r;
    assign pin_oe_n_out  = oe_n_r;
    assign pullup_en_out = pullup_r;
    assign reg_rdata_out = rdata_r;

endmodule

`default_nettype wire

// ===== verification/addr_high_io_checker_asserts.sv
// Assertion checker for the address-high general-purpose port
`timescale 1ns/1ps
`default_nettype none

`include "addr_high_io_defs.svh"

module addr_high_io_checker #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic             clk_in,
    input wire logic             rst_n_in,
    // Mode, standby and bus address
    input wire logic [1:0]       mode_in,
    input wire logic             hw_standby_in,
    input wire logic             sw_standby_in,
    input wire logic [WIDTH-1:0] bus_addr_hi_in,
    // Register port
    input wire logic [15:0]      reg_addr_in,
    input wire logic [WIDTH-1:0] reg_wdata_in,
    input wire logic             reg_wr_in,
    input wire logic             reg_rd_in,
    input wire logic [WIDTH-1:0] reg_rdata_out,
    // Pins
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic [WIDTH-1:0] pin_out,
    input wire logic [WIDTH-1:0] pin_oe_n_out,
    input wire logic [WIDTH-1:0] pullup_en_out
);
    logic [2:0] m1_cnt_r;   // Cycles spent in mode 1 outside hw standby
    logic [2:0] m1_cnt_nxt; // Saturates so it never wraps back to zero

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // Count settled mode 1 cycles; the start-up fill of ones takes a few
    always_comb begin
        m1_cnt_nxt = 3'h0;
        if (mode_in == `AHIO_MODE_CODE_1 && !hw_standby_in) begin
            m1_cnt_nxt = (m1_cnt_r == 3'h7) ? m1_cnt_r : m1_cnt_r + 3'h1;
        end
    end

    // Register the counter
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            m1_cnt_r <= 3'h0;
        end else begin
            m1_cnt_r <= m1_cnt_nxt;
        end
    end

    a_mode1_drive: assert property (m1_cnt_r >= 3'h5 |-> pin_oe_n_out == '0)
        else $error("Address pins not driven in mode 1");
    a_addr_follow: assert property (m1_cnt_r >= 3'h5 && !$past(sw_standby_in)
        |-> pin_out == $past(bus_addr_hi_in))
        else $error("Pins do not follow bus address");
    a_sw_addr_low: assert property (m1_cnt_r >= 3'h5 && $past(sw_standby_in)
        |-> pin_out == '0)
        else $error("Address pins not low in software standby");
    a_mode1_pullup: assert property (mode_in == `AHIO_MODE_CODE_1
        && $past(mode_in) == `AHIO_MODE_CODE_1 |-> pullup_en_out == '0)
        else $error("Pull-up on in mode 1");
    a_pullup_input: assert property ((pullup_en_out & ~pin_oe_n_out) == '0)
        else $error("Pull-up on a driven pin");
    a_hwsb_float: assert property (hw_standby_in
        |=> pin_oe_n_out == '1 && pullup_en_out == '0)
        else $error("Pins not floating in hardware standby");
    a_hwsb_clear: assert property (hw_standby_in && $past(hw_standby_in)
        && reg_rd_in && reg_addr_in == `AHIO_OFS_PULLUP
        |=> reg_rdata_out == '0)
        else $error("Pull-up control not cleared in standby");
    a_dir_readback: assert property (reg_rd_in
        && reg_addr_in == `AHIO_OFS_DIRECTION
        |=> reg_rdata_out == `AHIO_DIR_READBACK)
        else $error("Direction read value wrong");
    a_rd_idle: assert property (!reg_rd_in |=> reg_rdata_out == '0)
        else $error("Read data outside read cycle");

    // Main scenarios reached
    c_mode1_sleep: cover property (m1_cnt_r >= 3'h5 && sw_standby_in);
    c_hwsb_read: cover property (hw_standby_in && reg_rd_in);
    c_latch_read: cover property (reg_rd_in && reg_addr_in == `AHIO_OFS_LATCH);
endmodule

bind addr_high_io_port addr_high_io_checker #(.WIDTH(WIDTH)) i_addr_high_io_checker (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .mode_in(mode_in),
    .hw_standby_in(hw_standby_in), .sw_standby_in(sw_standby_in),
    .bus_addr_hi_in(bus_addr_hi_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out),
    .pullup_en_out(pullup_en_out));

`default_nettype wire

// ===== verification/addr_bus_ext_model.sv
// Board-side model: resolves each pin from device, board driver, pull-up
`timescale 1ns/1ps
`default_nettype none

module addr_bus_ext_model (
    // Clock
    input  wire logic       clk_in,
    // Device side of the pins
    input  wire logic [7:0] pin_out_in,
    input  wire logic [7:0] pin_oe_n_in,
    input  wire logic [7:0] pullup_in,
    // Board driver
    input  wire logic [7:0] ext_en_in,
    input  wire logic [7:0] ext_val_in,
    // Resolved pin level
    output wire logic [7:0] level_out
);
    logic [7:0] flt_r = 8'h00; // Undriven pins wander every cycle

    // A floating pin must never read as a steady level
    always @(posedge clk_in) begin
        flt_r <= ~flt_r;
    end

    // Device wins, then board driver, then pull-up, else floating
    assign level_out = (~pin_oe_n_in & pin_out_in)
                     | (pin_oe_n_in & ext_en_in & ext_val_in)
                     | (pin_oe_n_in & ~ext_en_in & (pullup_in | flt_r));
endmodule

`default_nettype wire

// ===== verification/addr_high_io_port_tb.sv
// Self-checking testbench for the address-high general-purpose port
`timescale 1ns/1ps
`default_nettype none

`include "addr_high_io_defs.svh"

module addr_high_io_port_tb;
    logic        clk = 1'b0;     // 20 MHz clock
    logic        rst_n = 1'b0;   // Reset, active low
    logic [1:0]  mode = 2'h3;    // Operating mode code
    logic        hw_sb = 1'b0;   // Hardware standby
    logic        sw_sb = 1'b0;   // Software standby
    logic [7:0]  bus_addr = 8'h3c;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  ext_en = 8'h0b; // Board drives pins 0, 1 and 3
    logic [7:0]  ext_val = 8'h01;
    logic [7:0]  rdata;
    logic [7:0]  level;
    logic [7:0]  pin_q;
    logic [7:0]  oe_n;
    logic [7:0]  pu;
    int          bad_count = 0;
    int          cmp_count = 0;

    always #25 clk = ~clk;

    addr_high_io_port i_addr_high_io_port (
        .clk_in(clk), .rst_n_in(rst_n), .mode_in(mode),
        .hw_standby_in(hw_sb), .sw_standby_in(sw_sb),
        .bus_addr_hi_in(bus_addr), .reg_addr_in(reg_addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .pin_in(level), .pin_out(pin_q),
        .pin_oe_n_out(oe_n), .pullup_en_out(pu));

    addr_bus_ext_model i_addr_bus_ext_model (
        .clk_in(clk), .pin_out_in(pin_q), .pin_oe_n_in(oe_n),
        .pullup_in(pu), .ext_en_in(ext_en), .ext_val_in(ext_val),
        .level_out(level));

    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // One-cycle read; data stands only in the following cycle
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    // Let registered outputs land, then sample off the edge
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        conclude();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        settle(4);
        chk(oe_n, 8'hff);
        chk(pu, 8'h00);
        rd_chk(`AHIO_OFS_PULLUP, 8'h00);
        rd_chk(`AHIO_OFS_DIRECTION, `AHIO_DIR_READBACK);
        rd_chk(16'hffb2, `AHIO_UNMAPPED_READ);
        // Single-chip: high nibble out, low nibble in with pull-ups on pins 0 and 2
        wr_reg(`AHIO_OFS_DIRECTION, 8'hf0);
        wr_reg(`AHIO_OFS_LATCH, 8'ha5);
        wr_reg(`AHIO_OFS_PULLUP, 8'hf5);
        settle(6);
        chk(oe_n, 8'h0f);
        chk(pin_q & 8'hf0, 8'ha0);
        chk(pu, 8'h05);
        rd_chk(`AHIO_OFS_LATCH, 8'ha5);
        rd_chk(`AHIO_OFS_PULLUP, 8'hf5);
        // Software standby holds outputs and drops writes
        @(posedge clk);
        sw_sb <= 1'b1;
        wr_reg(`AHIO_OFS_PULLUP, 8'h00);
        settle(3);
        chk(pin_q & 8'hf0, 8'ha0);
        chk(pu, 8'h05);
        @(posedge clk);
        sw_sb <= 1'b0;
        rd_chk(`AHIO_OFS_PULLUP, 8'hf5);
        // Mode 2: low nibble carries address, high nibble input
        @(posedge clk);
        mode <= 2'h2;
        wr_reg(`AHIO_OFS_DIRECTION, 8'h0f);
        settle(3);
        chk(oe_n, 8'hf0);
        chk(pin_q & 8'h0f, 8'h0c);
        chk(pu, 8'hf0);
        @(posedge clk);
        sw_sb <= 1'b1;
        settle(3);
        chk(pin_q & 8'h0f, 8'h00);
        chk(pu, 8'hf0);
        // Hardware standby floats pins and clears registers
        @(posedge clk);
        sw_sb <= 1'b0;
        hw_sb <= 1'b1;
        ext_en <= 8'hff;
        ext_val <= 8'h3c;
        settle(3);
        chk(oe_n, 8'hff);
        chk(pu, 8'h00);
        rd_chk(`AHIO_OFS_PULLUP, 8'h00);
        wr_reg(`AHIO_OFS_LATCH, 8'h77);
        @(posedge clk);
        hw_sb <= 1'b0;
        settle(6);
        chk(oe_n, 8'hff);
        rd_chk(`AHIO_OFS_LATCH, 8'h3c);
        wr_reg(`AHIO_OFS_DIRECTION, 8'hf0);
        settle(6);
        rd_chk(`AHIO_OFS_LATCH, 8'h0c);
        // Mode code 0 acts as single chip: high nibble shows the latch
        @(posedge clk);
        mode <= 2'h0;
        settle(2);
        chk(pin_q & 8'hf0, 8'h00);
        // Mode 1 from reset: all pins address, direction locked
        @(posedge clk);
        mode <= 2'h1;
        rst_n <= 1'b0;
        bus_addr <= 8'h96;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        settle(8);
        chk(oe_n, 8'h00);
        chk(pin_q, 8'h96);
        rd_chk(`AHIO_OFS_LATCH, 8'h00);
        wr_reg(`AHIO_OFS_DIRECTION, 8'h00);
        wr_reg(`AHIO_OFS_PULLUP, 8'hff);
        settle(3);
        chk(oe_n, 8'h00);
        chk(pu, 8'h00);
        rd_chk(`AHIO_OFS_LATCH, 8'h00);
        rd_chk(`AHIO_OFS_PULLUP, 8'hff);
        @(posedge clk);
        bus_addr <= 8'h5a;
        settle(2);
        chk(pin_q, 8'h5a);
        @(posedge clk);
        sw_sb <= 1'b1;
        settle(2);
        chk(pin_q, 8'h00);
        conclude();
    end
endmodule

`default_nettype wire
